/* hdl/rail_seq_regs.svh */
// Command codes, reset values, field positions and timing limits
// Assumes: included by bare name by the package and the port checker
`ifndef RAIL_SEQ_REGS_SVH
`define RAIL_SEQ_REGS_SVH
// ============================================================
// Command codes
`define C_CLEAR   8'h03
`define C_RATE    8'h27
`define C_GAIN    8'h38
`define C_OCF     8'h46
`define C_OCW     8'h4a
`define C_TONDLY  8'h60
`define C_RISE    8'h61
`define C_TONMAX  8'h62
`define C_TOFFDLY 8'h64
`define C_FALL    8'h65
`define C_TOFFMAX 8'h66
`define C_STWORD  8'h79
`define C_STVOUT  8'h7a
`define C_STIOUT  8'h7b
`define C_MASK    8'hd0
`define C_RESTART 8'hdc
// ============================================================
// Reset values
`define R_RATE    16'h82bf
`define R_GAIN    16'hca80
`define R_OCF     16'hdbb8
`define R_OCW     16'hda80
`define R_TONDLY  16'h8000
`define R_RISE    16'hd200
`define R_TONMAX  16'hd280
`define R_TOFFDLY 16'h8000
`define R_FALL    16'hd200
`define R_TOFFMAX 16'h8000
`define R_RESTART 16'hfbe8
`define R_MASK    8'h00
// ============================================================
// Status bit positions and alert mask positions
`define B_IOUT_OCF 7
`define B_IOUT_OCW 5
`define B_VOUT_TON 4
`define B_VOUT_TOFF 2
`define B_WORD_VOUT 15
`define B_WORD_IOUT 14
`define B_WORD_OFF 6
`define B_WORD_OC  4
`define M_OCW  0
`define M_OCF  1
`define M_TON  2
`define M_TOFF 3
// ============================================================
// Linear format fields
`define L11_EXP_HI 15
`define L11_EXP_LO 11
`define L11_MAN_HI 10
// Fraction bits: time kept in quarter ms, current scaled by 16
`define FRAC_TIME 2
`define FRAC_CUR  4
`define CUR_SHIFT 8
// Timing limits in quarter milliseconds
`define Q_TONDLY_MAX  22'h0510e0
`define Q_RISE_MAX    22'h001450
`define Q_TONMAX_MAX  22'h007d00
`define Q_TOFFDLY_MAX 22'h00fa00
`define Q_WARN_MIN    22'h0001e0
`define Q_WARN_MAX    22'h1ffb80
`define Q_REST_MIN    22'h000220
`define Q_REST_MAX    22'h03ffc0
`define Q_REST_STEP   6
`define Q_ZERO        22'h000000
// Timebase: quarter millisecond from a 40 ns clock
`define QTR_NS 250000
`define CLK_NS 40
`endif

/* hdl/rail_seq_pkg.sv */
// Types shared by the rail sequencer
// Assumes: the register header is on the include path
package rail_seq_pkg;
`include "rail_seq_regs.svh"
    // Gray codes along start, ramp, on, stop
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_TDLY  = 3'h1,
        S_RISE  = 3'h3,
        S_ON    = 3'h2,
        S_ODLY  = 3'h6,
        S_FALL  = 3'h7
    } seq_t;
    typedef struct packed {
        logic [15:0] rate;
        logic [15:0] gain;
        logic [15:0] ocf;
        logic [15:0] ocw;
        logic [15:0] tondly;
        logic [15:0] rise;
        logic [15:0] tonmax;
        logic [15:0] toffdly;
        logic [15:0] fall;
        logic [15:0] toffmax;
        logic [15:0] restart;
        logic [7:0]  mask;
    } cfg_t;
    typedef struct packed {
        cfg_t        cfg;
        seq_t        seq;
        logic [21:0] cnt;
        logic [21:0] tmax;
        logic        tmax_on;
        logic [21:0] warn;
        logic        warn_on;
        logic [21:0] hold;
        logic        hold_on;
        logic [15:0] tick_cnt;
        logic        tick;
        logic        run_s1, run_s2, run_prev;
        logic        uv_s1, uv_s2;
        logic        lo_s1, lo_s2;
        logic        var_s1, var_s2;
        logic [7:0]  st_iout;
        logic [7:0]  st_vout;
        logic [15:0] rdata;
        logic        err;
        logic        alert_n;
        logic        rail_en;
        logic        ramp_up;
        logic        ramp_dn;
        logic        ramp_step;
    } state_t;
endpackage

/* hdl/rail_seq.sv */
// Rail sequencing and overcurrent supervisor for one channel
// Assumes: command port is driven by a serial front end on SYS_CLK;
// run pin, output comparators and variant strap are asynchronous.
// Function
// - Flag overcurrent fault when phase current exceeds fault limit.
// - Current comes from sense minus reference voltage and monitor gain.
// - Ignore overcurrent faults during turn-on and turn-off ramps.
// - Warn limit exceeded sets status bits and alert unless masked.
// - Ignore overcurrent warnings during turn-on and turn-off ramps.
// - Limits and times are 16-bit linear: 5-bit exponent, 11-bit mantissa.
// - Falling run edge: drive run low for restart hold, then allow start.
// - Restart hold limited to 136 ms..65.52 s in 16 ms steps.
// - Wait turn-on delay before rise; delay limited to 0..83 s.
// - Rise over rise time up to 1.3 s; under 0.25 ms steps.
// - Turn-on fault if undervoltage limit not passed in time; zero disables.
// - Slew output at transition rate for new voltage or margin.
// - Slew variant ramps at transition rate, others use rise and fall.
// - Wait turn-off delay before fall; delay limited to 0..16 s.
// - Fall linearly over fall time then disable; under 0.25 ms steps.
// - After delay plus fall, warn if output not below one eighth.
// - Turn-off warning limit zero disables; else 120 ms..524 s.
module rail_seq
    import rail_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `QTR_NS / `CLK_NS
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [15:0] CMD_WDATA,
    input  wire logic        CMD_WR,
    input  wire logic        CMD_RD,
    output logic      [15:0] CMD_RDATA,
    output logic             CMD_ERR,
    input  wire logic [15:0] SENSE_MV,
    input  wire logic [15:0] REF_MV,
    input  wire logic [15:0] AVG_MV,
    input  wire logic        RUN_IN,
    output logic             RUN_OUT,
    output logic             RUN_OE,
    input  wire logic        UV_PASSED,
    input  wire logic        VOUT_LOW,
    input  wire logic        SLEW_VARIANT,
    input  wire logic        SLEW_DONE,
    output logic      [15:0] SLEW_RATE,
    output logic             RAIL_EN,
    output logic             RAMP_UP,
    output logic             RAMP_DN,
    output logic             RAMP_STEP,
    output logic             ALERT_N
);
    // ============================================================
    // Helpers
    // Linear word to unsigned value scaled by 2^sh, saturating
    function automatic logic [31:0] lin(input logic [15:0] w,
                                        input int sh);
        logic signed [5:0] t;
        logic [63:0] v;
        t = 6'(signed'(w[`L11_EXP_HI:`L11_EXP_LO])) + 6'(sh);
        v = {53'h0, w[`L11_MAN_HI:0]};
        if (w[`L11_MAN_HI]) begin
            v = 64'h0; // Negative reads as zero
        end else if (t >= 0) begin
            v = v << t;
        end else begin
            v = v >> (-t);
        end
        lin = (v[63:32] != 32'h0) ? 32'hffffffff : v[31:0];
    endfunction

    // Time word to quarter ms clamped into range
    function automatic logic [21:0] qtime(input logic [15:0] w,
                                          input logic [21:0] lo,
                                          input logic [21:0] hi);
        logic [31:0] v;
        v = lin(w, `FRAC_TIME);
        if (v > {10'h0, hi}) begin
            qtime = hi;
        end else if (v < {10'h0, lo}) begin
            qtime = lo;
        end else begin
            qtime = v[21:0];
        end
    endfunction

    // Sense voltage above limit times gain, both in mV
    function automatic logic over(input logic [15:0] mv,
                                  input logic [15:0] lim,
                                  input logic [15:0] gain);
        logic [31:0] a;
        logic [31:0] g;
        logic [63:0] p;
        a = lin(lim, `FRAC_CUR);
        g = lin(gain, `FRAC_CUR);
        p = a * g;
        over = {40'h0, mv, 8'h0} > p;
    endfunction

    state_t s_q, s_d;
    logic [21:0] tdly_q, rise_q, tmax_q, odly_q, fall_q;
    logic [21:0] warn_q, rest_q, rest_raw;
    logic [15:0] diff;
    logic        run_fall, stop_now, ramp, slew, imm;
    logic [7:0]  pend;

    // ============================================================
    // Decoded times and current
    always_comb begin
        tdly_q = qtime(s_q.cfg.tondly, `Q_ZERO, `Q_TONDLY_MAX);
        rise_q = qtime(s_q.cfg.rise, `Q_ZERO, `Q_RISE_MAX);
        tmax_q = qtime(s_q.cfg.tonmax, `Q_ZERO, `Q_TONMAX_MAX);
        odly_q = qtime(s_q.cfg.toffdly, `Q_ZERO, `Q_TOFFDLY_MAX);
        fall_q = qtime(s_q.cfg.fall, `Q_ZERO, `Q_RISE_MAX);
        warn_q = qtime(s_q.cfg.toffmax, `Q_WARN_MIN, `Q_WARN_MAX);
        rest_raw = qtime(s_q.cfg.restart, `Q_ZERO, `Q_REST_MAX);
        rest_raw[`Q_REST_STEP-1:0] = '0;
        rest_q = (rest_raw < `Q_REST_MIN) ? `Q_REST_MIN : rest_raw;
        diff = (SENSE_MV > REF_MV) ? SENSE_MV - REF_MV : 16'h0;
        slew = s_q.var_s2;
        imm = (odly_q == `Q_ZERO) && (fall_q == `Q_ZERO);
    end

    // ============================================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Synchronisers
        s_d.run_s1 = RUN_IN;
        s_d.run_s2 = s_q.run_s1;
        s_d.run_prev = s_q.run_s2;
        s_d.uv_s1 = UV_PASSED;
        s_d.uv_s2 = s_q.uv_s1;
        s_d.lo_s1 = VOUT_LOW;
        s_d.lo_s2 = s_q.lo_s1;
        s_d.var_s1 = SLEW_VARIANT;
        s_d.var_s2 = s_q.var_s1;
        run_fall = s_q.run_prev && !s_q.run_s2;

        // Common quarter ms timebase
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = 16'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 16'h1;
        end

        // Timers count down on the tick
        if (s_q.tick) begin
            if (s_q.cnt != `Q_ZERO) s_d.cnt = s_q.cnt - 22'h1;
            if (s_q.hold != `Q_ZERO) s_d.hold = s_q.hold - 22'h1;
            if (s_q.tmax != `Q_ZERO) s_d.tmax = s_q.tmax - 22'h1;
            if (s_q.warn != `Q_ZERO) s_d.warn = s_q.warn - 22'h1;
        end

        // Restart hold drives the run pin low
        if (run_fall && !s_q.hold_on) begin
            s_d.hold_on = 1'b1;
            s_d.hold = rest_q;
        end else if (s_q.hold_on && s_q.hold == `Q_ZERO) begin
            s_d.hold_on = 1'b0;
        end

        // Sequencer
        stop_now = !s_q.run_s2;
        case (s_q.seq)
            S_IDLE: begin
                if (s_q.run_s2 && !s_q.hold_on) begin
                    s_d.seq = S_TDLY;
                    s_d.cnt = tdly_q;
                    s_d.warn_on = 1'b0;
                end
            end
            S_TDLY: begin
                if (stop_now) begin
                    s_d.seq = S_IDLE;
                end else if (s_q.cnt == `Q_ZERO) begin
                    s_d.seq = S_RISE;
                    s_d.cnt = rise_q;
                    s_d.tmax = tmax_q;
                    s_d.tmax_on = (tmax_q != `Q_ZERO);
                end
            end
            S_RISE: begin
                if (stop_now) begin
                    s_d.seq = S_ODLY;
                    s_d.cnt = odly_q;
                end else if (slew ? SLEW_DONE
                                  : s_q.cnt == `Q_ZERO) begin
                    s_d.seq = S_ON;
                end
            end
            S_ON: begin
                if (stop_now) begin
                    s_d.seq = S_ODLY;
                    s_d.cnt = odly_q;
                end
            end
            S_ODLY: begin
                if (s_q.cnt == `Q_ZERO) begin
                    s_d.seq = S_FALL;
                    s_d.cnt = fall_q;
                end
            end
            S_FALL: begin
                if (slew ? SLEW_DONE : s_q.cnt == `Q_ZERO) begin
                    s_d.seq = S_IDLE;
                    s_d.warn = warn_q;
                    s_d.warn_on = !imm &&
                        (s_q.cfg.toffmax[`L11_MAN_HI:0] != 11'h0);
                end
            end
            default: s_d.seq = S_IDLE;
        endcase

        // Ramp outputs; rate serves new voltages and margins
        s_d.rail_en = (s_d.seq != S_IDLE);
        s_d.ramp_up = (s_d.seq == S_RISE);
        s_d.ramp_dn = (s_d.seq == S_FALL);
        s_d.ramp_step = !slew &&
            ((s_d.seq == S_RISE && rise_q == `Q_ZERO) ||
             (s_d.seq == S_FALL && fall_q == `Q_ZERO));

        // Command port: writes, clears and reads
        s_d.err = 1'b0;
        if (CMD_WR) begin
            case (CMD_CODE)
                `C_RATE:    s_d.cfg.rate = CMD_WDATA;
                `C_GAIN:    s_d.cfg.gain = CMD_WDATA;
                `C_OCF:     s_d.cfg.ocf = CMD_WDATA;
                `C_OCW:     s_d.cfg.ocw = CMD_WDATA;
                `C_TONDLY:  s_d.cfg.tondly = CMD_WDATA;
                `C_RISE:    s_d.cfg.rise = CMD_WDATA;
                `C_TONMAX:  s_d.cfg.tonmax = CMD_WDATA;
                `C_TOFFDLY: s_d.cfg.toffdly = CMD_WDATA;
                `C_FALL:    s_d.cfg.fall = CMD_WDATA;
                `C_TOFFMAX: s_d.cfg.toffmax = CMD_WDATA;
                `C_RESTART: s_d.cfg.restart = CMD_WDATA;
                `C_MASK:    s_d.cfg.mask = CMD_WDATA[7:0];
                `C_STIOUT:  s_d.st_iout = s_q.st_iout & ~CMD_WDATA[7:0];
                `C_STVOUT:  s_d.st_vout = s_q.st_vout & ~CMD_WDATA[7:0];
                `C_CLEAR: begin
                    s_d.st_iout = 8'h00;
                    s_d.st_vout = 8'h00;
                end
                default:    s_d.err = 1'b1;
            endcase
        end
        if (CMD_RD) begin
            case (CMD_CODE)
                `C_RATE:    s_d.rdata = s_q.cfg.rate;
                `C_GAIN:    s_d.rdata = s_q.cfg.gain;
                `C_OCF:     s_d.rdata = s_q.cfg.ocf;
                `C_OCW:     s_d.rdata = s_q.cfg.ocw;
                `C_TONDLY:  s_d.rdata = s_q.cfg.tondly;
                `C_RISE:    s_d.rdata = s_q.cfg.rise;
                `C_TONMAX:  s_d.rdata = s_q.cfg.tonmax;
                `C_TOFFDLY: s_d.rdata = s_q.cfg.toffdly;
                `C_FALL:    s_d.rdata = s_q.cfg.fall;
                `C_TOFFMAX: s_d.rdata = s_q.cfg.toffmax;
                `C_RESTART: s_d.rdata = s_q.cfg.restart;
                `C_MASK:    s_d.rdata = {8'h00, s_q.cfg.mask};
                `C_STIOUT:  s_d.rdata = {8'h00, s_q.st_iout};
                `C_STVOUT:  s_d.rdata = {8'h00, s_q.st_vout};
                `C_STWORD: begin
                    s_d.rdata = 16'h0;
                    s_d.rdata[`B_WORD_VOUT] = |s_q.st_vout;
                    s_d.rdata[`B_WORD_IOUT] = |s_q.st_iout;
                    s_d.rdata[`B_WORD_OFF] = !s_q.rail_en;
                    s_d.rdata[`B_WORD_OC] = s_q.st_iout[`B_IOUT_OCF];
                end
                default: begin
                    s_d.rdata = 16'h0;
                    s_d.err = 1'b1;
                end
            endcase
        end

        // Supervisors set status; a set beats a same-cycle clear
        ramp = (s_q.seq == S_RISE) || (s_q.seq == S_FALL);
        if (s_q.rail_en && !ramp &&
            over(diff, s_q.cfg.ocf, s_q.cfg.gain)) begin
            s_d.st_iout[`B_IOUT_OCF] = 1'b1;
        end
        if (s_q.rail_en && !ramp &&
            over(AVG_MV, s_q.cfg.ocw, s_q.cfg.gain)) begin
            s_d.st_iout[`B_IOUT_OCW] = 1'b1;
        end
        if (s_q.tmax_on) begin
            if (s_q.uv_s2 || s_q.seq == S_IDLE) begin
                s_d.tmax_on = 1'b0;
            end else if (s_q.tmax == `Q_ZERO) begin
                s_d.tmax_on = 1'b0;
                s_d.st_vout[`B_VOUT_TON] = 1'b1;
            end
        end
        if (s_q.warn_on && s_d.warn_on) begin
            if (s_q.lo_s2) begin
                s_d.warn_on = 1'b0;
            end else if (s_q.warn == `Q_ZERO) begin
                s_d.warn_on = 1'b0;
                s_d.st_vout[`B_VOUT_TOFF] = 1'b1;
            end
        end

        // Alert from unmasked pending status
        pend = 8'h00;
        pend[`M_OCW] = s_q.st_iout[`B_IOUT_OCW];
        pend[`M_OCF] = s_q.st_iout[`B_IOUT_OCF];
        pend[`M_TON] = s_q.st_vout[`B_VOUT_TON];
        pend[`M_TOFF] = s_q.st_vout[`B_VOUT_TOFF];
        s_d.alert_n = !(|(pend & ~s_q.cfg.mask));
    end

    // ============================================================
    // State register
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.cfg.rate <= `R_RATE;
            s_q.cfg.gain <= `R_GAIN;
            s_q.cfg.ocf <= `R_OCF;
            s_q.cfg.ocw <= `R_OCW;
            s_q.cfg.tondly <= `R_TONDLY;
            s_q.cfg.rise <= `R_RISE;
            s_q.cfg.tonmax <= `R_TONMAX;
            s_q.cfg.toffdly <= `R_TOFFDLY;
            s_q.cfg.fall <= `R_FALL;
            s_q.cfg.toffmax <= `R_TOFFMAX;
            s_q.cfg.restart <= `R_RESTART;
            s_q.cfg.mask <= `R_MASK;
            s_q.alert_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Outputs straight from the state register; RUN_OUT is a constant
    assign CMD_RDATA = s_q.rdata;
    assign CMD_ERR   = s_q.err;
    assign RUN_OUT   = 1'b0; // Only ever pulls low
    assign RUN_OE    = s_q.hold_on;
    assign SLEW_RATE = s_q.cfg.rate;
    assign RAIL_EN   = s_q.rail_en;
    assign RAMP_UP   = s_q.ramp_up;
    assign RAMP_DN   = s_q.ramp_dn;
    assign RAMP_STEP = s_q.ramp_step;
    assign ALERT_N   = s_q.alert_n;

endmodule // rail_seq

/* sim/rail_seq_props.sv */
// Port checker for the rail sequencer
// Assumes: bound to rail_seq; one clock, async active-low reset
`include "rail_seq_regs.svh"
module rail_seq_props
    import rail_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `QTR_NS / `CLK_NS
) (
    input wire logic        SYS_CLK,
    input wire logic        RESET_N,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic        CMD_WR,
    input wire logic        CMD_RD,
    input wire logic [15:0] CMD_RDATA,
    input wire logic        CMD_ERR,
    input wire logic        RUN_IN,
    input wire logic        RUN_OE,
    input wire logic [15:0] SLEW_RATE,
    input wire logic        RAIL_EN,
    input wire logic        RAMP_UP,
    input wire logic        RAMP_DN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // ====================================================
    // Run pin: hold after a falling edge, start when free
    sequence run_fall; $fell(RUN_IN); endsequence
    sequence hold_soon; ##[1:6] RUN_OE; endsequence
    sequence run_free; $rose(RUN_IN) && !RAIL_EN && !RUN_OE; endsequence
    AST_RUN_HOLD: assert property (run_fall |-> hold_soon)
        else $error("run pin not held after falling edge");
    AST_NO_START: assert property ($rose(RAIL_EN) |-> !RUN_OE)
        else $error("rail started during restart hold");
    AST_START: assert property (run_free |-> ##[1:6] RAIL_EN)
        else $error("rail did not start after run rose");
    // ====================================================
    // Ramps
    AST_UP_RAIL: assert property ($rose(RAMP_UP) |-> RAIL_EN && !RAMP_DN)
        else $error("rise ramp outside enabled rail");
    AST_FALL_OFF: assert property ($fell(RAMP_DN) |-> ##[0:1] !RAIL_EN)
        else $error("rail not disabled after fall");
    // ====================================================
    // Command port
    AST_RD_HOLD: assert property (!$past(CMD_RD) |-> $stable(CMD_RDATA))
        else $error("read data changed without a read");
    AST_ERR: assert property (CMD_ERR |-> $past(CMD_WR || CMD_RD))
        else $error("error pulse without a strobe");
    AST_RATE: assert property (CMD_WR && CMD_CODE == `C_RATE |=>
        SLEW_RATE == $past(CMD_WDATA))
        else $error("slew rate not taken from write");
endmodule // rail_seq_props
bind rail_seq rail_seq_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CMD_CODE(CMD_CODE),
    .CMD_WDATA(CMD_WDATA), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
    .CMD_RDATA(CMD_RDATA), .CMD_ERR(CMD_ERR), .RUN_IN(RUN_IN),
    .RUN_OE(RUN_OE), .SLEW_RATE(SLEW_RATE), .RAIL_EN(RAIL_EN),
    .RAMP_UP(RAMP_UP), .RAMP_DN(RAMP_DN));

/* sim/rail_stage_model.sv */
// Power stage and run pin model beside the rail sequencer
// Assumes: SYS_CLK timing; run pin has a pull-up
module rail_stage_model (
    input  wire logic SYS_CLK,
    input  wire logic RAIL_EN,
    input  wire logic RUN_OE,
    input  wire logic RUN_OUT,
    input  wire logic host_run,
    input  wire logic uv_ok,
    input  wire logic vlow_ok,
    input  wire logic slew_ok,
    output logic      RUN_IN,
    output logic      UV_PASSED,
    output logic      VOUT_LOW,
    output logic      SLEW_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] on_cnt = 8'h00;
    logic [7:0] off_cnt = 8'h00;
    // Open-drain run pin: high unless a party pulls it down
    assign RUN_IN = !((RUN_OE && !RUN_OUT) || !host_run);
    // Output voltage settles some cycles after the rail changes
    always @(posedge SYS_CLK) begin
        on_cnt <= RAIL_EN ? on_cnt + {7'h00, on_cnt != 8'hff} : 8'h00;
        off_cnt <= RAIL_EN ? 8'h00 : off_cnt + {7'h00, off_cnt != 8'hff};
    end
    // Either check can be held back to provoke a fault
    assign UV_PASSED = uv_ok && RAIL_EN && on_cnt >= 8'h0a;
    assign VOUT_LOW = vlow_ok && !RAIL_EN && off_cnt >= 8'h05;
    // Slew engine reports its ramp done 48 cycles into the enabled rail
    assign SLEW_DONE = slew_ok && RAIL_EN && on_cnt >= 8'h30;
endmodule // rail_stage_model

/* sim/tb_top.sv */
// Self-checking bench for the rail sequencer
// Assumes: package, design and stage model compiled first
module tb_top
    import rail_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    typedef struct packed {
        logic [7:0]  code;
        logic        err;
        logic [15:0] val;
    } row_t;
    localparam row_t ROWS [9] = '{
        '{8'h27, 1'b0, 16'h82bf}, '{8'h60, 1'b0, 16'h8000},
        '{8'h61, 1'b0, 16'hd200}, '{8'h62, 1'b0, 16'hd280},
        '{8'h64, 1'b0, 16'h8000}, '{8'h65, 1'b0, 16'hd200},
        '{8'h66, 1'b0, 16'h8000}, '{8'hdc, 1'b0, 16'hfbe8},
        '{8'h55, 1'b1, 16'h0000}};
    logic        SYS_CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic [7:0]  CMD_CODE = 8'h00;
    logic [15:0] CMD_WDATA = 16'h0000;
    logic        CMD_WR = 1'b0;
    logic        CMD_RD = 1'b0;
    logic [15:0] SENSE_MV = 16'h0000;
    logic [15:0] REF_MV = 16'h0000;
    logic [15:0] AVG_MV = 16'h0000;
    logic        host_run = 1'b0;
    logic        uv_ok = 1'b0;
    logic        vlow_ok = 1'b1;
    logic        oc_ramp = 1'b0, slew_var = 1'b0;
    logic        stp;
    logic [15:0] CMD_RDATA, SLEW_RATE;
    logic        CMD_ERR, RUN_IN, RUN_OUT, RUN_OE, UV_PASSED, VOUT_LOW;
    logic        SLEW_DONE, RAIL_EN, RAMP_UP, RAMP_DN, RAMP_STEP, ALERT_N;
    int          fails = 0;
    int          checks = 0;
    int          t_enr, t_upr, t_upf, t_dnr, t_dnf, t_al, t_oer, t_oef, t_x;
    rail_seq #(.TICK_CYCLES(TICK)) dut_u (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CMD_CODE(CMD_CODE),
        .CMD_WDATA(CMD_WDATA), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
        .CMD_RDATA(CMD_RDATA), .CMD_ERR(CMD_ERR), .SENSE_MV(SENSE_MV),
        .REF_MV(REF_MV), .AVG_MV(AVG_MV), .RUN_IN(RUN_IN),
        .RUN_OUT(RUN_OUT), .RUN_OE(RUN_OE), .UV_PASSED(UV_PASSED),
        .VOUT_LOW(VOUT_LOW), .SLEW_VARIANT(slew_var), .SLEW_DONE(SLEW_DONE),
        .SLEW_RATE(SLEW_RATE), .RAIL_EN(RAIL_EN), .RAMP_UP(RAMP_UP),
        .RAMP_DN(RAMP_DN), .RAMP_STEP(RAMP_STEP), .ALERT_N(ALERT_N));
    rail_stage_model stage_u (
        .SYS_CLK(SYS_CLK), .RAIL_EN(RAIL_EN), .RUN_OE(RUN_OE),
        .RUN_OUT(RUN_OUT), .host_run(host_run), .uv_ok(uv_ok),
        .vlow_ok(vlow_ok), .slew_ok(slew_var), .RUN_IN(RUN_IN),
        .UV_PASSED(UV_PASSED),
        .VOUT_LOW(VOUT_LOW), .SLEW_DONE(SLEW_DONE));
    // =====================================================
    // Helpers
    task cyc;
        @(posedge SYS_CLK);
        #1;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task rng(input int v, input int lo, input int hi);
        chk(v >= lo && v <= hi, 1);
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d);
        CMD_CODE = c;
        CMD_WDATA = d;
        CMD_WR = 1'b1;
        cyc;
        CMD_WR = 1'b0;
        cyc;
    endtask
    task rd(input logic [7:0] c, input logic e, input logic [15:0] v);
        CMD_CODE = c;
        CMD_RD = 1'b1;
        cyc;
        CMD_RD = 1'b0;
        chk({CMD_ERR, CMD_RDATA}, {e, v});
        cyc;
    endtask
    task ev(input logic s, input int i, inout int r, inout int f);
        if (s === 1'b1 && r < 0) r = i;
        if (s === 1'b0 && r >= 0 && f < 0) f = i;
    endtask
    // Run n cycles noting when ramps and run hold first rise and fall, and when enable and alert first assert
    task watch(input int n, input int rel);
        {t_enr, t_upr, t_upf, t_dnr, t_dnf, t_al, t_oer, t_oef} = '1;
        t_x = -1;
        stp = 1'b0;
        for (int i = 0; i < n; i++) begin
            cyc;
            if (i == rel) host_run = 1'b1;
            ev(RAIL_EN, i, t_enr, t_x);
            ev(RAMP_UP, i, t_upr, t_upf);
            ev(RAMP_DN, i, t_dnr, t_dnf);
            ev(RUN_OE, i, t_oer, t_oef);
            ev(!ALERT_N, i, t_al, t_x);
            stp |= (RAMP_STEP === 1'b1);
            if (oc_ramp && t_upr == i) begin
                AVG_MV = 16'd120;
                SENSE_MV = 16'd200;
            end
            if (t_upf == i) begin
                AVG_MV = 16'd0;
                SENSE_MV = 16'd0;
            end
        end
    endtask
    task close_out;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // =====================================================
    // Clock and hang guard
    initial forever #20 SYS_CLK = ~SYS_CLK;
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        fails++;
        close_out;
    end
    // Main sequence; times use exponent -2 so mantissa counts ticks
    initial begin
        repeat (16) @(posedge SYS_CLK);
        #1 RESET_N = 1'b1;
        foreach (ROWS[k]) rd(ROWS[k].code, ROWS[k].err, ROWS[k].val);
        $display("done: defaults");
        wr(8'h60, 16'hf004);
        wr(8'h61, 16'hf008);
        wr(8'h62, 16'hf00c);
        wr(8'h64, 16'hf004);
        wr(8'h65, 16'hf008);
        wr(8'h66, 16'hf001);
        wr(8'h27, 16'h1234);
        chk(SLEW_RATE, 16'h1234);
        // Start with output stuck low and current high during rise
        oc_ramp = 1'b1;
        host_run = 1'b1;
        watch(200, -1);
        oc_ramp = 1'b0;
        rng(t_upr - t_enr, 12, 21);
        rng(t_upf - t_upr, 28, 37);
        rng(t_al - t_upr, 44, 53);
        rd(8'h7b, 1'b0, 16'h0000);
        rd(8'h7a, 1'b0, 16'h0010);
        $display("done: start");
        // Warning only, then fault once the reference no longer offsets
        uv_ok = 1'b1;
        wr(8'h03, 16'h0000);
        SENSE_MV = 16'd200;
        REF_MV = 16'd100;
        AVG_MV = 16'd120;
        repeat (4) cyc;
        rd(8'h7b, 1'b0, 16'h0020);
        rd(8'h79, 1'b0, 16'h4000);
        chk(ALERT_N, 1'b0);
        REF_MV = 16'd0;
        repeat (4) cyc;
        rd(8'h7b, 1'b0, 16'h00a0);
        rd(8'h79, 1'b0, 16'h4010);
        wr(8'hd0, 16'h0003);
        wr(8'h03, 16'h0000);
        repeat (4) cyc;
        rd(8'h7b, 1'b0, 16'h00a0);
        chk(ALERT_N, 1'b1);
        SENSE_MV = 16'd0;
        AVG_MV = 16'd0;
        wr(8'hd0, 16'h0000);
        wr(8'h03, 16'h0000);
        $display("done: overcurrent");
        // Stop with output stuck high, default restart hold
        vlow_ok = 1'b0;
        host_run = 1'b0;
        watch(8100, 10);
        rng(t_dnr, 14, 25);
        rng(t_dnf - t_dnr, 28, 37);
        rng(t_al - t_dnf, 1912, 1930);
        rng(t_oef - t_oer, 7930, 7942);
        rd(8'h7a, 1'b0, 16'h0004);
        $display("done: stop");
        // Short hold clamps up; zero fall steps down
        vlow_ok = 1'b1;
        wr(8'h03, 16'h0000);
        wr(8'hdc, 16'hf001);
        wr(8'h65, 16'h8000);
        repeat (100) cyc;
        host_run = 1'b0;
        watch(2400, 10);
        rng(t_oef - t_oer, 2170, 2182);
        chk(stp, 1'b1);
        chk(t_al, 32'hffffffff);
        $display("done: restart clamp");
        // Reset in mid-run, then restart in the slew variant
        slew_var = 1'b1;
        RESET_N = 1'b0;
        repeat (2) cyc;
        chk({SLEW_RATE, RAIL_EN, RUN_OE, ALERT_N}, {16'h82bf, 3'b001});
        RESET_N = 1'b1;
        rd(8'h66, 1'b0, 16'h8000);
        watch(200, -1);
        rng(t_upf - t_enr, 44, 54);
        $display("done: reset");
        close_out;
    end
endmodule // tb_top
